// >>> hw/heater_current_alarm_monitor.sv
// Implementation choices: the APB register port and the register offsets.
`timescale 1ns/1ps
`include "heater_alarm_defines.svh"

module heater_current_alarm_monitor
  import heater_alarm_pkg::*;
#(
  parameter int unsigned CNT_W = 20,
  parameter int unsigned SKIP_CYC = `HCA_SKIP_MS * `HCA_CLK_KHZ,
  parameter int unsigned BRK_FAST_CYC = `HCA_BRK_FAST_MS * `HCA_CLK_KHZ,
  parameter int unsigned SHT_FAST_CYC = `HCA_SHT_FAST_MS * `HCA_CLK_KHZ
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Sensing
  input wire logic i_heat_output_on,
  input wire logic [15:0] i_current_transformer_input_ch1,
  input wire logic [15:0] i_current_transformer_input_ch2,
  // Alarms and display
  output logic [1:0] o_heater_break_alarm,
  output logic [1:0] o_relay_short_alarm,
  output logic o_any_alarm,
  output logic [2:0] o_flash_sel,
  output logic [15:0] o_flash_value
);

  state_t s;
  state_t n;
  logic setup;
  logic access;
  logic wr;
  logic th_reg;
  logic mapped;
  logic bad;
  logic brk_en;
  logic sht_en;
  logic [CNT_W-1:0] brk_lim;
  logic [CNT_W-1:0] sht_lim;
  logic [1:0][15:0] meas;

  assign setup = i_psel & ~i_penable;
  assign access = i_psel & i_penable;
  assign wr = access & i_pwrite;
  assign brk_en = s.ctrl[`HCA_CTRL_BRK_EN];
  assign sht_en = s.ctrl[`HCA_CTRL_SHT_EN];
  assign meas[0] = i_current_transformer_input_ch1;
  assign meas[1] = i_current_transformer_input_ch2;

  // Zero-wait slave; read data is captured in the setup cycle
  assign o_pready = access;
  assign o_prdata = s.rdata;
  assign o_pslverr = access & bad;
  assign o_heater_break_alarm = s.brk;
  assign o_relay_short_alarm = s.sht;
  assign o_any_alarm = |{s.brk, s.sht};
  assign o_flash_sel = s.flash_sel;
  assign o_flash_value = s.flash_val;

  always_comb begin
    mapped = 1'b1;
    case (i_paddr)
      `HCA_ADDR_CTRL, `HCA_ADDR_BRK_TH1, `HCA_ADDR_BRK_TH2,
      `HCA_ADDR_SHT_TH1, `HCA_ADDR_SHT_TH2, `HCA_ADDR_HEAT_MON1,
      `HCA_ADDR_HEAT_MON2, `HCA_ADDR_LEAK_MON1, `HCA_ADDR_LEAK_MON2,
      `HCA_ADDR_STATUS: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  assign th_reg = (i_paddr == `HCA_ADDR_BRK_TH1) | (i_paddr == `HCA_ADDR_BRK_TH2) |
                  (i_paddr == `HCA_ADDR_SHT_TH1) | (i_paddr == `HCA_ADDR_SHT_TH2);
  // Out-of-range thresholds are refused, keeping the old value
  assign bad = ~mapped | (i_pwrite & th_reg &
               ((|i_pwdata[31:16]) | (i_pwdata[15:0] > `HCA_TH_MAX)));

  // Faster control periods shorten the dead time
  assign brk_lim = s.ctrl[`HCA_CTRL_FAST_PERIOD] ? CNT_W'(BRK_FAST_CYC)
                                                  : CNT_W'(SKIP_CYC);
  assign sht_lim = s.ctrl[`HCA_CTRL_FAST_PERIOD] ? CNT_W'(SHT_FAST_CYC)
                                                  : CNT_W'(SKIP_CYC);

  always_comb begin
    logic act;
    logic [15:0] coded;
    logic on_long;
    logic off_long;
    n = s;
    act = 1'b0;
    coded = 16'h0000;
    on_long = 1'b0;
    off_long = 1'b0;
    // Run length of the current output state, saturating
    n.heat_prev = i_heat_output_on;
    if (i_heat_output_on != s.heat_prev) begin
      n.run_cnt = '0;
    end else if (s.run_cnt != '1) begin
      n.run_cnt = s.run_cnt + 20'h00001;
    end
    on_long = i_heat_output_on & s.heat_prev & (s.run_cnt >= brk_lim);
    off_long = ~i_heat_output_on & ~s.heat_prev & (s.run_cnt >= sht_lim);

    // Each channel uses only its own input and thresholds
    for (int ch = 0; ch < 2; ch++) begin
      act = (ch == 0) | s.ctrl[`HCA_CTRL_TWO_CT];
      coded = (meas[ch] > `HCA_MON_MAX) ? `HCA_MON_OVR : meas[ch];
      if (!brk_en || !act) begin
        n.heat_mon[ch] = 16'h0000;
      end else if (on_long) begin
        n.heat_mon[ch] = coded;
      end
      if (!sht_en || !act) begin
        n.leak_mon[ch] = 16'h0000;
      end else if (off_long) begin
        n.leak_mon[ch] = coded;
      end
      n.brk[ch] = brk_en & act & ((s.brk_th[ch] == `HCA_TH_MAX) |
                  ((s.brk_th[ch] != `HCA_TH_MIN) &
                   (s.heat_mon[ch] < s.brk_th[ch])));
      n.sht[ch] = sht_en & act & ((s.sht_th[ch] == `HCA_TH_MIN) |
                  ((s.sht_th[ch] != `HCA_TH_MAX) &
                   (s.leak_mon[ch] > s.sht_th[ch])));
    end

    // Display flash, one value at a time: channel 2 break, then channel 1 short, channel 2 short, channel 1 break
    if (n.brk[1]) begin
      n.flash_sel = FLASH_HEAT2;
      n.flash_val = n.heat_mon[1];
    end else if (n.sht[0]) begin
      n.flash_sel = FLASH_LEAK1;
      n.flash_val = n.leak_mon[0];
    end else if (n.sht[1]) begin
      n.flash_sel = FLASH_LEAK2;
      n.flash_val = n.leak_mon[1];
    end else if (n.brk[0]) begin
      n.flash_sel = FLASH_HEAT1;
      n.flash_val = n.heat_mon[0];
    end else begin
      n.flash_sel = FLASH_NONE;
      n.flash_val = 16'h0000;
    end

    // Register writes at the access phase
    if (wr && !bad) begin
      case (i_paddr)
        `HCA_ADDR_CTRL: n.ctrl = i_pwdata[3:0];
        `HCA_ADDR_BRK_TH1: n.brk_th[0] = i_pwdata[15:0];
        `HCA_ADDR_BRK_TH2: n.brk_th[1] = i_pwdata[15:0];
        `HCA_ADDR_SHT_TH1: n.sht_th[0] = i_pwdata[15:0];
        `HCA_ADDR_SHT_TH2: n.sht_th[1] = i_pwdata[15:0];
        default: n.ctrl = s.ctrl;
      endcase
    end

    // Read data captured in the setup cycle
    if (setup && !i_pwrite) begin
      case (i_paddr)
        `HCA_ADDR_CTRL: n.rdata = {28'h0000000, s.ctrl};
        `HCA_ADDR_BRK_TH1: n.rdata = {16'h0000, s.brk_th[0]};
        `HCA_ADDR_BRK_TH2: n.rdata = {16'h0000, s.brk_th[1]};
        `HCA_ADDR_SHT_TH1: n.rdata = {16'h0000, s.sht_th[0]};
        `HCA_ADDR_SHT_TH2: n.rdata = {16'h0000, s.sht_th[1]};
        `HCA_ADDR_HEAT_MON1: n.rdata = {16'h0000, s.heat_mon[0]};
        `HCA_ADDR_HEAT_MON2: n.rdata = {16'h0000, s.heat_mon[1]};
        `HCA_ADDR_LEAK_MON1: n.rdata = {16'h0000, s.leak_mon[0]};
        `HCA_ADDR_LEAK_MON2: n.rdata = {16'h0000, s.leak_mon[1]};
        `HCA_ADDR_STATUS: n.rdata = {25'h0000000, s.flash_sel, s.sht, s.brk};
        default: n.rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      s <= '0;
      s.ctrl <= `HCA_CTRL_RST;
      s.brk_th <= {`HCA_BRK_TH_RST, `HCA_BRK_TH_RST};
      s.sht_th <= {`HCA_SHT_TH_RST, `HCA_SHT_TH_RST};
      s.flash_sel <= FLASH_NONE;
    end else begin
      s <= n;
    end
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);

  property p_brk_forced_off;
    s.brk_th[0] == `HCA_TH_MIN |=> !s.brk[0];
  endproperty
  a_brk_forced_off: assert property (p_brk_forced_off)
    else $error("break alarm on with zero threshold");

  property p_brk_forced_on;
    (s.brk_th[1] == `HCA_TH_MAX) && brk_en && s.ctrl[`HCA_CTRL_TWO_CT] |=> s.brk[1];
  endproperty
  a_brk_forced_on: assert property (p_brk_forced_on)
    else $error("break alarm off with full threshold");

  property p_brk_compare;
    brk_en && (s.brk_th[0] != `HCA_TH_MIN) && (s.brk_th[0] != `HCA_TH_MAX)
      |=> s.brk[0] == ($past(s.heat_mon[0]) < $past(s.brk_th[0]));
  endproperty
  a_brk_compare: assert property (p_brk_compare)
    else $error("break alarm disagrees with compare");

  property p_sht_forced;
    sht_en && (s.sht_th[0] == `HCA_TH_MIN) |=> s.sht[0];
  endproperty
  a_sht_forced: assert property (p_sht_forced)
    else $error("short alarm off with zero threshold");

  property p_sht_compare;
    sht_en && (s.sht_th[0] != `HCA_TH_MIN) && (s.sht_th[0] != `HCA_TH_MAX)
      |=> s.sht[0] == ($past(s.leak_mon[0]) > $past(s.sht_th[0]));
  endproperty
  a_sht_compare: assert property (p_sht_compare)
    else $error("short alarm disagrees with compare");

  property p_mon_range;
    (s.heat_mon[0] <= `HCA_MON_MAX) || (s.heat_mon[0] == `HCA_MON_OVR);
  endproperty
  a_mon_range: assert property (p_mon_range)
    else $error("heater monitor outside range");

  property p_heat_hold_off;
    brk_en && !i_heat_output_on |=> $stable(s.heat_mon[0]);
  endproperty
  a_heat_hold_off: assert property (p_heat_hold_off)
    else $error("heater monitor moved while output off");

  property p_leak_skip_short;
    sht_en && i_heat_output_on ##1 !i_heat_output_on |=> $stable(s.leak_mon[0]);
  endproperty
  a_leak_skip_short: assert property (p_leak_skip_short)
    else $error("leakage sampled right after turn-off");

  property p_brk_disable;
    !brk_en |=> (s.brk == 2'b00) && (s.heat_mon[1] == 16'h0000);
  endproperty
  a_brk_disable: assert property (p_brk_disable)
    else $error("break logic active while disabled");

  property p_sht_disable;
    !sht_en |=> s.sht == 2'b00;
  endproperty
  a_sht_disable: assert property (p_sht_disable)
    else $error("short alarm while disabled");

  property p_flash_ch2;
    s.brk[1] |-> (s.flash_sel == FLASH_HEAT2) && (s.flash_val == s.heat_mon[1]);
  endproperty
  a_flash_ch2: assert property (p_flash_ch2)
    else $error("channel two current not flashed");

endmodule : heater_current_alarm_monitor

// >>> hw/heater_alarm_defines.svh
`ifndef HEATER_ALARM_DEFINES_SVH
`define HEATER_ALARM_DEFINES_SVH

// Register byte offsets
`define HCA_ADDR_CTRL 8'h00
`define HCA_ADDR_BRK_TH1 8'h04
`define HCA_ADDR_BRK_TH2 8'h08
`define HCA_ADDR_SHT_TH1 8'h0C
`define HCA_ADDR_SHT_TH2 8'h10
`define HCA_ADDR_HEAT_MON1 8'h14
`define HCA_ADDR_HEAT_MON2 8'h18
`define HCA_ADDR_LEAK_MON1 8'h1C
`define HCA_ADDR_LEAK_MON2 8'h20
`define HCA_ADDR_STATUS 8'h24

// Control field positions
`define HCA_CTRL_BRK_EN 0
`define HCA_CTRL_SHT_EN 1
`define HCA_CTRL_TWO_CT 2
`define HCA_CTRL_FAST_PERIOD 3

// Values in 0.1 A steps
`define HCA_TH_MIN 16'h0000
`define HCA_TH_MAX 16'h01F4
`define HCA_MON_MAX 16'h0226
`define HCA_MON_OVR 16'hFFFF
`define HCA_BRK_TH_RST 16'h0000
`define HCA_SHT_TH_RST 16'h01F4
`define HCA_CTRL_RST 4'h0

// Timing
`define HCA_CLK_KHZ 10000
`define HCA_SKIP_MS 100
`define HCA_BRK_FAST_MS 30
`define HCA_SHT_FAST_MS 35

`endif

// >>> hw/heater_alarm_pkg.sv
package heater_alarm_pkg;

  typedef enum logic [2:0] {
    FLASH_NONE = 3'b000,
    FLASH_HEAT1 = 3'b001,
    FLASH_HEAT2 = 3'b010,
    FLASH_LEAK1 = 3'b011,
    FLASH_LEAK2 = 3'b100
  } flash_sel_t;

  typedef struct packed {
    logic [3:0] ctrl;
    logic [1:0][15:0] brk_th;
    logic [1:0][15:0] sht_th;
    logic [1:0][15:0] heat_mon;
    logic [1:0][15:0] leak_mon;
    logic [1:0] brk;
    logic [1:0] sht;
    logic heat_prev;
    logic [19:0] run_cnt;
    flash_sel_t flash_sel;
    logic [15:0] flash_val;
    logic [31:0] rdata;
  } state_t;

endpackage : heater_alarm_pkg

// >>> tb/ct_sensor_model.sv
`timescale 1ns/1ps
module ct_sensor_model (
  // Clock and heater state
  input wire logic i_clk_sys,
  input wire logic i_heat_on,
  // Currents to present
  input wire logic [15:0] i_on1,
  input wire logic [15:0] i_on2,
  input wire logic [15:0] i_lk1,
  input wire logic [15:0] i_lk2,
  // Transformer readings
  output logic [15:0] o_ct1,
  output logic [15:0] o_ct2
);
  // One cycle late, as a real reading lags the switch
  always_ff @(posedge i_clk_sys) begin
    o_ct1 <= i_heat_on ? i_on1 : i_lk1;
    o_ct2 <= i_heat_on ? i_on2 : i_lk2;
  end
endmodule : ct_sensor_model

// >>> tb/heater_current_alarm_monitor_test.sv
`timescale 1ns/1ps
`include "heater_alarm_defines.svh"
module heater_current_alarm_monitor_test;
  typedef struct packed {
    logic [3:0] c;
    logic [15:0] bt, st, n1, n2, k1, k2;
    logic [1:0] eb, es;
    logic [2:0] fs;
  } row_t;
  localparam row_t ROWS [6] = '{
    '{4'h7, 16'h64, 16'hA, 16'h50, 16'h96, 16'h5, 16'h14, 2'b01, 2'b10, 3'h4},
    '{4'h7, 16'h0, 16'h1F4, 16'h0, 16'h0, 16'h226, 16'h226, 2'b00, 2'b00, 3'h0},
    '{4'h7, 16'h1F4, 16'h0, 16'h226, 16'h226, 16'h0, 16'h0, 2'b11, 2'b11, 3'h2},
    '{4'h3, 16'h64, 16'hA, 16'h50, 16'h50, 16'h5, 16'h14, 2'b01, 2'b00, 3'h1},
    '{4'h0, 16'h64, 16'h0, 16'h0, 16'h0, 16'h14, 16'h14, 2'b00, 2'b00, 3'h0},
    '{4'h7, 16'h1F3, 16'h1F3, 16'h227, 16'h1F3, 16'h227, 16'h1F3, 2'b00, 2'b01, 3'h3}
  };
  logic clk, rst, psel, pen, pwr, heat, pready, perr, any, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] n1, n2, k1, k2, ct1, ct2, fval;
  logic [1:0] brk, sht;
  logic [2:0] fsel;
  int error_cnt, compares;

  ct_sensor_model ct (
    .i_clk_sys(clk), .i_heat_on(heat), .i_on1(n1), .i_on2(n2),
    .i_lk1(k1), .i_lk2(k2), .o_ct1(ct1), .o_ct2(ct2)
  );

  // Short skip windows keep the run brief
  heater_current_alarm_monitor #(.SKIP_CYC(20), .BRK_FAST_CYC(6), .SHT_FAST_CYC(7)) dut (
    .i_clk_sys(clk), .i_sys_rst(rst), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(perr), .i_heat_output_on(heat),
    .i_current_transformer_input_ch1(ct1), .i_current_transformer_input_ch2(ct2),
    .o_heater_break_alarm(brk), .o_relay_short_alarm(sht), .o_any_alarm(any),
    .o_flash_sel(fsel), .o_flash_value(fval)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic complete_run;
    if (error_cnt == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h, wanted %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {psel, pwr, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = perr;
    {psel, pen} <= 2'b00;
  endtask : apb

  task automatic cfg(input logic [3:0] c, input logic [15:0] bt, input logic [15:0] st);
    apb(1'b1, `HCA_ADDR_BRK_TH1, 32'(bt));
    apb(1'b1, `HCA_ADDR_BRK_TH2, 32'(bt));
    apb(1'b1, `HCA_ADDR_SHT_TH1, 32'(st));
    apb(1'b1, `HCA_ADDR_SHT_TH2, 32'(st));
    apb(1'b1, `HCA_ADDR_CTRL, 32'(c));
  endtask : cfg

  task automatic pulse(input int on_c, input int off_c);
    heat <= 1'b1;
    repeat (on_c) @(posedge clk);
    heat <= 1'b0;
    repeat (off_c) @(posedge clk);
  endtask : pulse

  function automatic logic [31:0] mon(input logic [15:0] v, input logic en);
    if (!en) return 32'h0;
    return (v > `HCA_MON_MAX) ? 32'(`HCA_MON_OVR) : 32'(v);
  endfunction : mon

  // Flashed value is the monitor of the channel named by the flash code
  function automatic logic [31:0] fval_exp(input row_t r);
    case (r.fs)
      3'h1: return mon(r.n1, r.c[0]);
      3'h2: return mon(r.n2, r.c[0]);
      3'h3: return mon(r.k1, r.c[1]);
      3'h4: return mon(r.k2, r.c[1]);
      default: return 32'h0;
    endcase
  endfunction : fval_exp

  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    complete_run();
  end

  initial begin
    rst = 1'b1;
    {psel, pen, pwr, heat} = 4'h0;
    {paddr, pwdata} = '0;
    {n1, n2, k1, k2} = '0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0);
      chk(rd, (i > 2) ? 32'h1F4 : 32'h0);
    end
    apb(1'b1, `HCA_ADDR_BRK_TH1, 32'h1F5);
    chk(32'(err), 32'h1);
    apb(1'b0, `HCA_ADDR_BRK_TH1, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h28, 32'h0);
    chk(32'(err), 32'h1);
    chk(rd, 32'h0);
    foreach (ROWS[r]) begin
      cfg(ROWS[r].c, ROWS[r].bt, ROWS[r].st);
      {n1, n2, k1, k2} <= {ROWS[r].n1, ROWS[r].n2, ROWS[r].k1, ROWS[r].k2};
      pulse(25, 25);
      chk(32'(brk), 32'(ROWS[r].eb));
      chk(32'(sht), 32'(ROWS[r].es));
      chk(32'(fsel), 32'(ROWS[r].fs));
      chk(32'(any), 32'(|{ROWS[r].eb, ROWS[r].es}));
      chk(32'(fval), fval_exp(ROWS[r]));
      apb(1'b0, `HCA_ADDR_STATUS, 32'h0);
      chk(rd, 32'({ROWS[r].fs, ROWS[r].es, ROWS[r].eb}));
      apb(1'b0, `HCA_ADDR_HEAT_MON1, 32'h0);
      chk(rd, mon(ROWS[r].n1, ROWS[r].c[0]));
      apb(1'b0, `HCA_ADDR_LEAK_MON1, 32'h0);
      chk(rd, mon(ROWS[r].k1, ROWS[r].c[1]));
    end
    // Too-short pulses must leave the held samples alone
    cfg(4'h7, 16'h64, 16'hA);
    n1 <= 16'h96;
    pulse(25, 25);
    n1 <= 16'h10;
    pulse(15, 25);
    chk(32'(brk), 32'h0);
    cfg(4'hF, 16'h64, 16'hA);
    pulse(15, 25);
    chk(32'(brk), 32'h1);
    k1 <= 16'h5;
    pulse(25, 5);
    pulse(25, 0);
    chk(32'(sht[0]), 32'h1);
    repeat (25) @(posedge clk);
    chk(32'(sht[0]), 32'h0);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    chk(32'({brk, sht}), 32'h0);
    complete_run();
  end
endmodule : heater_current_alarm_monitor_test
